// File: core/scsi_msg_pkg.sv
package scsi_msg_pkg;
    // message codes
    localparam logic [7:0] MSG_RESTORE = 8'h03;
    localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
    localparam logic [7:0] MSG_DISCONNECT = 8'h04;
    localparam logic [7:0] MSG_INIT_ERR = 8'h05;
    localparam logic [7:0] MSG_REJECT = 8'h07;
    localparam logic [7:0] MSG_NOP = 8'h08;
    localparam logic [7:0] MSG_PARITY_ERR = 8'h09;
    localparam logic [7:0] MSG_LINKED_DONE = 8'h0A;
    localparam logic [7:0] MSG_WIDE_RESIDUE = 8'h23;
    localparam logic [7:0] RESIDUE_UPPER = 8'h01;
    // identify byte layout
    localparam int IDENT_BIT = 7;
    localparam int GRANT_BIT = 6;
    localparam int LUN_W = 6;
    // timing
    localparam int CLK_NS = 5;
    localparam int DISC_DELAY_NS = 1000;
    localparam int HOLD_W = 16;
    localparam logic [HOLD_W-1:0] DISC_DELAY_CYC =
        HOLD_W'((DISC_DELAY_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        PH_FREE = 2'b00,
        PH_MSGOUT = 2'b01,
        PH_MSGIN = 2'b10,
        PH_OTHER = 2'b11
    } phase_e;
endpackage : scsi_msg_pkg

// File: core/scsi_msg_if.sv
`timescale 1ns/10ps
interface scsi_msg_if;
    import scsi_msg_pkg::*;
    logic bsy;
    phase_e phase;
    logic req;
    logic [7:0] tgtData;
    logic ack;
    logic atn;
    logic [7:0] iniData;

    modport target (
        output bsy, phase, req, tgtData,
        input ack, atn, iniData
    );
    modport initiator (
        input bsy, phase, req, tgtData,
        output ack, atn, iniData
    );
endinterface : scsi_msg_if

// File: core/link_byte_hs.sv
`timescale 1ns/10ps
module link_byte_hs import scsi_msg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // command
    input wire logic start,
    input wire logic [7:0] txByte,
    // link
    input wire logic linkAck,
    input wire logic linkAtn,
    input wire logic [7:0] linkData,
    output logic linkReq,
    output logic [7:0] txData,
    // result
    output logic done,
    output logic [7:0] rxByte,
    output logic atnAtAck
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_REQ = 2'b01,
        HS_REL = 2'b10
    } hs_e;

    hs_e st_q;

    // four-phase req/ack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= HS_IDLE;
            linkReq <= 1'b0;
        end else begin
            case (st_q)
                HS_IDLE: begin
                    if (start) begin
                        linkReq <= 1'b1;
                        st_q <= HS_REQ;
                    end
                end
                HS_REQ: begin
                    if (linkAck) begin
                        linkReq <= 1'b0;
                        st_q <= HS_REL;
                    end
                end
                HS_REL: begin
                    if (!linkAck) begin
                        st_q <= HS_IDLE;
                    end
                end
                default: st_q <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= (st_q == HS_REL) && !linkAck;
        end
    end

    // byte and attention sampled at ack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txData <= 8'h00;
            rxByte <= 8'h00;
            atnAtAck <= 1'b0;
        end else begin
            if (start && st_q == HS_IDLE) begin
                txData <= txByte;
            end
            if (st_q == HS_REQ && linkAck) begin
                rxByte <= linkData;
                atnAtAck <= linkAtn;
            end
        end
    end
endmodule : link_byte_hs

// File: core/scsi_msg_target.sv
// Behaviour
// - initiator drops attention before last acknowledge
// - codes 80h to FFh are IDENTIFY
// - DISCONNECT without attention, then release BSY
// - split transfers end with save then disconnect
// - no DISCONNECT under information unit agreement
// - initiator DISCONNECT: send disconnect or release BSY
// - hold off arbitration for the larger delay
// - reject DISCONNECT when disabled or unable
// - IDENTIFY: bit7 one, bit6 grant, low LUN
// - no grant, no disconnect; sent grant zero
// - BUSY status when ungranted and reconnect needed
// - changed LUN in IDENTIFY forces bus free
// - initiator restores pointers after reconnect identify
// - selection identification succeeds without errors
// - reselection identification succeeds without attention
// - send wide residue right after data-in
// - wide residue is 23h then 01h
// - error recovery restores saved pointers
// - initiator resets pointers after linked completion
// - parity error message without attention: bus free
// - parity retry resends whole message-in message
// - reject interlock, unsolicited reject rejected
`timescale 1ns/10ps
module scsi_msg_target import scsi_msg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    scsi_msg_if.target link,
    // connection requests
    input wire logic selected,
    input wire logic reselect,
    input wire logic [LUN_W-1:0] reselLun,
    // commands
    input wire logic cmdDisconnect,
    input wire logic cmdResidue,
    input wire logic cmdLinkedDone,
    // configuration
    input wire logic iuMode,
    input wire logic discEnable,
    input wire logic canDisconnect,
    input wire logic pendingTasks,
    input wire logic needReconnect,
    input wire logic [HOLD_W-1:0] physLimit,
    // status
    output logic nexusValid_q,
    output logic [LUN_W-1:0] nexusLun_q,
    output logic grantFlag_q,
    output logic busyStatus_q,
    output logic identOk_q,
    output logic ptrRestore_q,
    output logic unexpFree_q,
    output logic cmdRefused_q,
    output logic arbBlocked_q
);
    typedef enum logic [2:0] {
        T_FREE = 3'b000,
        T_HOLD = 3'b001,
        T_CONN = 3'b010,
        T_OUT = 3'b011,
        T_OUTW = 3'b100,
        T_IN = 3'b101,
        T_INW = 3'b110
    } tstate_e;

    tstate_e st_q;
    logic [7:0] msg0_q, msg1_q, txByte_q;
    logic msgLen2_q, idx_q, freeAfter_q, msgAtn_q, resel_q, hsStart_q;
    logic [HOLD_W-1:0] holdCnt_q;
    logic hsDone, hsAtn;
    logic [7:0] rxByte;
    // decoded action
    logic actSend, actLen2, actFree, actRelease, actResend;
    logic actIdent, actBad, actRestore, actRefuse;
    logic [7:0] actB0, actB1;
    logic [HOLD_W-1:0] holdLoad;

    link_byte_hs hs (
        .clk(clk),
        .rst_n(rst_n),
        .start(hsStart_q),
        .txByte(txByte_q),
        .linkAck(link.ack),
        .linkAtn(link.atn),
        .linkData(link.iniData),
        .linkReq(link.req),
        .txData(link.tgtData),
        .done(hsDone),
        .rxByte(rxByte),
        .atnAtAck(hsAtn)
    );

    assign holdLoad = (physLimit > DISC_DELAY_CYC) ? physLimit
                                                  : DISC_DELAY_CYC;

    always_comb begin
        actSend = 1'b0;
        actLen2 = 1'b0;
        actFree = 1'b0;
        actRelease = 1'b0;
        actResend = 1'b0;
        actIdent = 1'b0;
        actBad = 1'b0;
        actRestore = 1'b0;
        actRefuse = 1'b0;
        actB0 = MSG_REJECT;
        actB1 = MSG_DISCONNECT;
        if (st_q == T_OUTW && hsDone) begin
            if (rxByte[IDENT_BIT]) begin
                if (nexusValid_q && rxByte[LUN_W-1:0] != nexusLun_q) begin
                    actRelease = 1'b1;
                    actBad = 1'b1;
                end else begin
                    actIdent = 1'b1;
                end
            end else begin
                case (rxByte)
                    MSG_DISCONNECT: begin
                        if (discEnable && canDisconnect && grantFlag_q) begin
                            if (iuMode) begin
                                actRelease = 1'b1;
                            end else begin
                                actSend = 1'b1;
                                actLen2 = 1'b1;
                                actFree = 1'b1;
                                actB0 = MSG_SAVE_PTR;
                            end
                        end else begin
                            actSend = 1'b1;
                        end
                    end
                    MSG_PARITY_ERR: begin
                        if (msgAtn_q) begin
                            actResend = 1'b1;
                        end else begin
                            actRelease = 1'b1;
                            actBad = 1'b1;
                        end
                    end
                    MSG_REJECT: begin
                        actSend = !msgAtn_q;
                    end
                    MSG_INIT_ERR: begin
                        actSend = 1'b1;
                        actB0 = MSG_RESTORE;
                        actRestore = 1'b1;
                    end
                    MSG_NOP: begin
                        actSend = 1'b0;
                    end
                    default: actSend = 1'b1;
                endcase
            end
        end else if (st_q == T_CONN) begin
            if (cmdDisconnect) begin
                if (iuMode || !grantFlag_q) begin
                    actRefuse = 1'b1;
                end else begin
                    actSend = 1'b1;
                    actLen2 = 1'b1;
                    actFree = 1'b1;
                    actB0 = MSG_SAVE_PTR;
                end
            end else if (cmdResidue) begin
                if (iuMode) begin
                    actRefuse = 1'b1;
                end else begin
                    actSend = 1'b1;
                    actLen2 = 1'b1;
                    actB0 = MSG_WIDE_RESIDUE;
                    actB1 = RESIDUE_UPPER;
                end
            end else if (cmdLinkedDone) begin
                actSend = 1'b1;
                actB0 = MSG_LINKED_DONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= T_FREE;
            link.bsy <= 1'b0;
            link.phase <= PH_FREE;
            msg0_q <= 8'h00;
            msg1_q <= 8'h00;
            msgLen2_q <= 1'b0;
            idx_q <= 1'b0;
            freeAfter_q <= 1'b0;
            msgAtn_q <= 1'b0;
            resel_q <= 1'b0;
            hsStart_q <= 1'b0;
            txByte_q <= 8'h00;
            holdCnt_q <= '0;
        end else begin
            hsStart_q <= 1'b0;
            case (st_q)
                T_FREE: begin
                    if (selected) begin
                        link.bsy <= 1'b1;
                        link.phase <= PH_MSGOUT;
                        st_q <= T_OUT;
                    end else if (reselect) begin
                        msg0_q <= {1'b1, 1'b0, reselLun};
                        msgLen2_q <= 1'b0;
                        freeAfter_q <= 1'b0;
                        resel_q <= 1'b1;
                        idx_q <= 1'b0;
                        msgAtn_q <= 1'b0;
                        link.bsy <= 1'b1;
                        link.phase <= PH_MSGIN;
                        st_q <= T_IN;
                    end
                end
                T_HOLD: begin
                    if (holdCnt_q == '0) begin
                        st_q <= T_FREE;
                    end else begin
                        holdCnt_q <= holdCnt_q - 1'b1;
                    end
                end
                T_CONN: begin
                    if (actSend) begin
                        msg0_q <= actB0;
                        msg1_q <= actB1;
                        msgLen2_q <= actLen2;
                        freeAfter_q <= actFree;
                        idx_q <= 1'b0;
                        msgAtn_q <= 1'b0;
                        link.phase <= PH_MSGIN;
                        st_q <= T_IN;
                    end else if (link.atn) begin
                        link.phase <= PH_MSGOUT;
                        st_q <= T_OUT;
                    end
                end
                T_OUT: begin
                    hsStart_q <= 1'b1;
                    st_q <= T_OUTW;
                end
                T_OUTW: begin
                    if (hsDone) begin
                        if (actRelease) begin
                            link.bsy <= 1'b0;
                            link.phase <= PH_FREE;
                            holdCnt_q <= holdLoad;
                            st_q <= T_HOLD;
                        end else if (actSend || actResend) begin
                            if (actSend) begin
                                msg0_q <= actB0;
                                msg1_q <= actB1;
                                msgLen2_q <= actLen2;
                                freeAfter_q <= actFree;
                            end
                            idx_q <= 1'b0;
                            msgAtn_q <= 1'b0;
                            link.phase <= PH_MSGIN;
                            st_q <= T_IN;
                        end else if (hsAtn) begin
                            st_q <= T_OUT;
                        end else begin
                            link.phase <= PH_OTHER;
                            st_q <= T_CONN;
                        end
                    end
                end
                T_IN: begin
                    txByte_q <= idx_q ? msg1_q : msg0_q;
                    hsStart_q <= 1'b1;
                    st_q <= T_INW;
                end
                T_INW: begin
                    if (hsDone) begin
                        msgAtn_q <= msgAtn_q | hsAtn;
                        if (msgLen2_q && !idx_q) begin
                            idx_q <= 1'b1;
                            st_q <= T_IN;
                        end else begin
                            resel_q <= 1'b0;
                            if (freeAfter_q && !(msgAtn_q | hsAtn)) begin
                                link.bsy <= 1'b0;
                                link.phase <= PH_FREE;
                                holdCnt_q <= holdLoad;
                                st_q <= T_HOLD;
                            end else if (link.atn) begin
                                link.phase <= PH_MSGOUT;
                                st_q <= T_OUT;
                            end else begin
                                link.phase <= PH_OTHER;
                                st_q <= T_CONN;
                            end
                        end
                    end
                end
                default: st_q <= T_FREE;
            endcase
        end
    end

    // nexus bookkeeping
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nexusValid_q <= 1'b0;
            nexusLun_q <= '0;
            grantFlag_q <= 1'b0;
        end else if (st_q == T_HOLD || st_q == T_FREE) begin
            nexusValid_q <= (st_q == T_FREE) && reselect;
            if (st_q == T_FREE && reselect) begin
                nexusLun_q <= reselLun;
            end
        end else if (actIdent) begin
            nexusValid_q <= 1'b1;
            nexusLun_q <= rxByte[LUN_W-1:0];
            grantFlag_q <= rxByte[GRANT_BIT];
        end
    end

    // event pulses and status
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            identOk_q <= 1'b0;
            ptrRestore_q <= 1'b0;
            unexpFree_q <= 1'b0;
            cmdRefused_q <= 1'b0;
            busyStatus_q <= 1'b0;
            arbBlocked_q <= 1'b0;
        end else begin
            identOk_q <= actIdent || (st_q == T_INW && hsDone && resel_q
                                      && !hsAtn);
            ptrRestore_q <= actRestore || (st_q == T_FREE && reselect);
            unexpFree_q <= actBad;
            cmdRefused_q <= actRefuse;
            busyStatus_q <= nexusValid_q && !grantFlag_q && pendingTasks
                            && needReconnect;
            arbBlocked_q <= (st_q == T_HOLD) && (holdCnt_q != '0);
        end
    end
endmodule : scsi_msg_target

// File: core/scsi_msg_initiator.sv
`timescale 1ns/10ps
module scsi_msg_initiator import scsi_msg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    scsi_msg_if.initiator link,
    // outgoing message bytes
    input wire logic outValid,
    input wire logic [7:0] outByte,
    input wire logic outLast,
    output logic outTaken_q,
    // attention control
    input wire logic atnRequest,
    input wire logic parErrIn,
    // incoming message bytes
    output logic rxValid_q,
    output logic [7:0] rxByte_q,
    output logic ptrRestore_q,
    output logic ptrReset_q,
    output logic residue_q
);
    logic stepPend_q, residuePend_q;
    logic take;

    assign take = link.req && !link.ack && !stepPend_q;

    // byte step: present data and attention, then acknowledge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link.ack <= 1'b0;
            link.atn <= 1'b0;
            link.iniData <= 8'h00;
            stepPend_q <= 1'b0;
        end else begin
            if (link.ack && !link.req) begin
                link.ack <= 1'b0;
            end else if (stepPend_q) begin
                link.ack <= 1'b1;
                stepPend_q <= 1'b0;
            end else if (take) begin
                stepPend_q <= 1'b1;
                if (link.phase == PH_MSGOUT) begin
                    link.iniData <= outValid ? outByte : MSG_NOP;
                    if (!outValid || outLast) begin
                        link.atn <= 1'b0;
                    end
                end else if (link.phase == PH_MSGIN && parErrIn) begin
                    link.atn <= 1'b1;
                end
            end
            if (atnRequest) begin
                link.atn <= 1'b1;
            end
        end
    end

    // message-in decode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outTaken_q <= 1'b0;
            rxValid_q <= 1'b0;
            rxByte_q <= 8'h00;
            ptrRestore_q <= 1'b0;
            ptrReset_q <= 1'b0;
            residue_q <= 1'b0;
            residuePend_q <= 1'b0;
        end else begin
            outTaken_q <= take && link.phase == PH_MSGOUT && outValid;
            rxValid_q <= 1'b0;
            ptrRestore_q <= 1'b0;
            ptrReset_q <= 1'b0;
            residue_q <= 1'b0;
            if (take && link.phase == PH_MSGIN) begin
                rxValid_q <= 1'b1;
                rxByte_q <= link.tgtData;
                residuePend_q <= !residuePend_q
                                 && link.tgtData == MSG_WIDE_RESIDUE;
                if (residuePend_q) begin
                    residue_q <= link.tgtData == RESIDUE_UPPER;
                end else begin
                    ptrRestore_q <= link.tgtData[IDENT_BIT]
                                    || link.tgtData == MSG_RESTORE;
                    ptrReset_q <= link.tgtData == MSG_LINKED_DONE;
                end
            end
        end
    end
endmodule : scsi_msg_initiator

// File: verification/scsi_link_monitor.sv
`timescale 1ns/10ps
module scsi_link_monitor import scsi_msg_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link
    input wire logic bsy,
    input wire phase_e phase,
    input wire logic req,
    input wire logic [7:0] tgtData,
    input wire logic ack,
    input wire logic atn,
    input wire logic [7:0] iniData
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    req_hold_a: assert property (
        req && !ack |=> req && $stable(tgtData)) else $error("req fell early");
    ack_hold_a: assert property (
        ack && req |=> ack && $stable(iniData)) else $error("ack fell early");
    ack_answer_a: assert property (
        $rose(req) |-> ##[1:4] ack) else $error("no ack");
    ack_release_a: assert property (
        ack && !req |=> !ack) else $error("ack stuck");
    free_idle_a: assert property (
        !bsy |-> phase == PH_FREE) else $error("phase without bsy");
    ident_grant_a: assert property (
        req && phase == PH_MSGIN && tgtData[IDENT_BIT] |-> !tgtData[GRANT_BIT])
        else $error("grant set in sent identify");
    residue_pair_a: assert property (
        $rose(req) && phase == PH_MSGIN && tgtData == MSG_WIDE_RESIDUE
        |-> ##[1:20] ($rose(req) && tgtData == RESIDUE_UPPER))
        else $error("residue count missing");
    save_disc_a: assert property (
        $rose(req) && phase == PH_MSGIN && tgtData == MSG_SAVE_PTR
        |-> ##[1:20] ($rose(req) && tgtData == MSG_DISCONNECT))
        else $error("save not followed by disconnect");
    disc_free_a: assert property (
        phase == PH_MSGIN && req && ack && !atn && tgtData == MSG_DISCONNECT
        |-> ##[1:12] !bsy) else $error("bsy kept after disconnect");
endmodule : scsi_link_monitor

// File: verification/scsi_link_control_msg_handler_bench.sv
`timescale 1ns/10ps
module scsi_link_control_msg_handler_bench import scsi_msg_pkg::*;;
    typedef struct packed {
        logic [7:0] id;
        logic [7:0] msg;
        logic [2:0] cfg;
        logic [7:0] rx;
        logic free;
    } row_s;
    row_s rows [11] = '{'{8'hC3, 8'h04, 3'b011, 8'h04, 1'b1},
        '{8'hC3, 8'h04, 3'b111, 8'h00, 1'b1},
        '{8'hC3, 8'h04, 3'b001, 8'h07, 1'b0},
        '{8'hC3, 8'h04, 3'b010, 8'h07, 1'b0},
        '{8'h83, 8'h04, 3'b011, 8'h07, 1'b0},
        '{8'hC3, 8'h05, 3'b011, 8'h03, 1'b0},
        '{8'hC3, 8'h07, 3'b011, 8'h07, 1'b0},
        '{8'hC3, 8'h09, 3'b011, 8'h00, 1'b1},
        '{8'hC3, 8'h81, 3'b011, 8'h00, 1'b1},
        '{8'hC3, 8'hC3, 3'b011, 8'h00, 1'b0},
        '{8'hFF, 8'h08, 3'b011, 8'h00, 1'b0}};
    logic clk, rst_n, clr, sel, resel, cDisc, cRes, cLink, iu, en, can;
    logic pend, need, outValid, outLast, atnReq, outTaken, rxValid, bsyQ;
    logic nValid, busySt, unexpFree, refused, arbBlk, ptrI, ptrReset, residue;
    logic gFlag, idOk, ptrT;
    logic [5:0] reselLun, nLun;
    logic [7:0] seen;
    logic [15:0] physLimit;
    logic [7:0] outByte, rxByte, lastRx;
    int errorCnt = 0, samplesChecked = 0, cycles = 0, holdCnt, n;
    scsi_msg_if ifc ();
    scsi_msg_target u_scsi_msg_target (.clk(clk), .rst_n(rst_n),
        .link(ifc.target), .selected(sel), .reselect(resel),
        .reselLun(reselLun), .cmdDisconnect(cDisc), .cmdResidue(cRes),
        .cmdLinkedDone(cLink), .iuMode(iu), .discEnable(en),
        .canDisconnect(can), .pendingTasks(pend), .needReconnect(need),
        .physLimit(physLimit), .nexusValid_q(nValid), .nexusLun_q(nLun),
        .grantFlag_q(gFlag), .busyStatus_q(busySt), .identOk_q(idOk),
        .ptrRestore_q(ptrT), .unexpFree_q(unexpFree), .cmdRefused_q(refused),
        .arbBlocked_q(arbBlk));
    scsi_msg_initiator u_scsi_msg_initiator (.clk(clk), .rst_n(rst_n),
        .link(ifc.initiator), .outValid(outValid), .outByte(outByte),
        .outLast(outLast), .outTaken_q(outTaken), .atnRequest(atnReq),
        .parErrIn(1'b0), .rxValid_q(rxValid), .rxByte_q(rxByte),
        .ptrRestore_q(ptrI), .ptrReset_q(ptrReset), .residue_q(residue));
    scsi_link_monitor u_scsi_link_monitor (.clk(clk), .rst_n(rst_n),
        .bsy(ifc.bsy), .phase(ifc.phase), .req(ifc.req),
        .tgtData(ifc.tgtData), .ack(ifc.ack), .atn(ifc.atn),
        .iniData(ifc.iniData));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        bsyQ <= ifc.bsy;
        if (clr) begin
            seen <= '0;
            lastRx <= 8'h00;
            holdCnt <= 0;
        end else begin
            seen <= seen | {idOk, ptrT, ptrI, refused, unexpFree, residue,
                ptrReset, bsyQ & ~ifc.bsy};
            holdCnt <= holdCnt + int'(arbBlk === 1'b1);
            if (rxValid === 1'b1) lastRx <= rxByte;
        end
        if (cycles == 20000) begin
            errorCnt++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input int k);
        rst_n = 0;
        clr = 1;
        repeat (k) @(negedge clk);
        rst_n = 1;
        clr = 0;
    endtask : do_reset
    task automatic send(input logic [7:0] b, input logic last);
        outValid = 1;
        outByte = b;
        outLast = last;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (outTaken !== 1'b1 && n < 200);
    endtask : send
    task automatic connect(input logic [7:0] id, input logic [7:0] msg);
        do_reset(2);
        atnReq = 1;
        sel = 1;
        @(negedge clk);
        atnReq = 0;
        sel = 0;
        send(id, 1'b0);
        send(msg, 1'b1);
        outValid = 0;
        repeat (80) @(negedge clk);
    endtask : connect
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {rst_n, clr, sel, resel, cDisc, cRes, cLink, iu, en, can} = '0;
        {pend, need, outValid, outLast, atnReq} = '0;
        reselLun = '0;
        outByte = '0;
        physLimit = 16'h000A;
        do_reset(20);
        chk({2'h0, ifc.bsy, ifc.req, ifc.ack, ifc.atn, nValid, arbBlk}, 0);
        $display("reset test done");
        for (int i = 0; i < 11; i++) begin
            {iu, en, can} = rows[i].cfg;
            connect(rows[i].id, rows[i].msg);
            chk(lastRx, rows[i].rx);
            chk({7'h00, seen[0]}, {7'h00, rows[i].free});
            chk({7'h00, gFlag}, {7'h00, rows[i].id[GRANT_BIT]});
            chk({7'h00, seen[7]}, 8'h01);
            chk({7'h00, seen[6]}, {7'h00, rows[i].msg == MSG_INIT_ERR});
            $display("row %0d done", i);
        end
        do_reset(2);
        {pend, need} = 2'b11;
        reselLun = 6'h05;
        resel = 1;
        @(negedge clk);
        resel = 0;
        repeat (60) @(negedge clk);
        chk(lastRx, 8'h85);
        chk({7'h00, busySt}, 8'h01);
        chk({2'b00, nLun}, 8'h05);
        for (int k = 0; k < 3; k++) begin
            {cDisc, cRes, cLink} = 3'b100 >> k;
            @(negedge clk);
            {cDisc, cRes, cLink} = 3'b000;
            repeat (40) @(negedge clk);
        end
        chk(seen, 8'hF6);
        $display("reselect test done");
        for (int k = 0; k < 2; k++) begin
            physLimit = k ? 16'h012C : 16'h000A;
            {iu, en, can} = k ? 3'b011 : 3'b111;
            connect(8'hC3, MSG_DISCONNECT);
            repeat (400) @(negedge clk);
            n = k ? 300 : 200;
            chk({7'h00, holdCnt inside {[n:n + 1]}}, 8'h01);
            $display("hold test %0d done", k);
        end
        report_and_stop();
    end
endmodule : scsi_link_control_msg_handler_bench
